//--- dsr_pkg.sv
package dsr_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] ADDR_PRESET_BASE    = 8'h00;
    localparam logic [7:0] ADDR_STATUS         = 8'h20;
    localparam logic [7:0] ADDR_REF_SOURCE     = 8'h24;
    localparam logic [7:0] ADDR_INPUT_FUNC     = 8'h28;
    localparam logic [7:0] ADDR_FREQ_LIMITS    = 8'h2C;
    localparam logic [7:0] ADDR_NET_SPEED_REF  = 8'h30;
    localparam logic [7:0] ADDR_RATED_FREQ     = 8'h34;
    localparam logic [7:0] ADDR_COMMAND        = 8'h38;
    localparam logic [7:0] ADDR_ACTIVE_REF     = 8'h3C;
    localparam logic [7:0] ADDR_POT_REF        = 8'h40;

    localparam int PRESET_COUNT = 8;

    // Reference limits in 0.1 Hz units
    localparam logic signed [15:0] PRESET_MAX      = 16'sh0BB8;
    localparam logic signed [15:0] PRESET_MIN      = -16'sh0BB8;
    localparam logic [15:0]        PRESET_RESET    = 16'h0000;
    localparam logic [15:0]        MIN_LIMIT_RESET = 16'h001E;
    localparam logic [15:0]        MAX_LIMIT_RESET = 16'h0294;
    localparam logic [15:0]        RATED_RESET     = 16'h0258;
    localparam logic [15:0]        POT_STEP        = 16'h0001;
    localparam int                 NET_SHIFT       = 13;

    // Reference source codes
    localparam logic [3:0] SRC_PRESET = 4'h8;
    localparam logic [3:0] SRC_POT    = 4'h7;
    localparam logic [3:0] SRC_NET    = 4'h9;

    // Digital input function codes
    localparam logic [7:0] FN_PRESET_MSB = 8'h0D;
    localparam logic [7:0] FN_PRESET_MID = 8'h0E;
    localparam logic [7:0] FN_PRESET_LSB = 8'h0F;
    localparam logic [7:0] FN_POT_UP_A   = 8'h0B;
    localparam logic [7:0] FN_POT_UP_B   = 8'h21;
    localparam logic [7:0] FN_POT_DN_A   = 8'h0C;
    localparam logic [7:0] FN_POT_DN_B   = 8'h22;

    // Command word bits
    localparam int CMD_RAMP_EN = 0;
    localparam int CMD_GEN_EN  = 1;
    localparam int CMD_FWD     = 2;
    localparam int CMD_JOG     = 3;
    localparam int CMD_REMOTE  = 4;
    localparam int CMD_RAMP2   = 5;

    // Status word bits
    localparam int ST_RAMP2  = 5;
    localparam int ST_CONFIG = 6;
    localparam int ST_ALARM  = 7;
    localparam int ST_RUN    = 8;
    localparam int ST_ENABLE = 9;
    localparam int ST_FWD    = 10;
    localparam int ST_JOG    = 11;
    localparam int ST_REMOTE = 12;
    localparam int ST_UNDERV = 13;
    localparam int ST_FAULT  = 15;
endpackage

//--- dsr_top.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// How it works
// - Three inputs pick one of eight presets
// - Inputs at 0 V add weights 4/2/1
// - Presets clamp to plus/minus 300.0 Hz
// - Negative preset reverses the commanded direction
// - MSB on both inputs 0 and 1 forces config fault, refuse enable
// - Source code 7 selects potentiometer
// - Codes 11/33 raise, 12/34 lower potentiometer
// - Both active while disabled resets potentiometer
// - Network 8192 equals rated frequency
// - One read-only 16-bit status word
// - Bit 5 shows second ramp pair
// - Bit 6 shows configuration fault
// - Bit 7 shows alarm
// - Bit 8 shows running
// - Bit 9 shows fully enabled
// - Bit 10 shows forward rotation
// - Bit 11 shows jog active
// - Bit 12 shows remote mode
// - Bit 13 shows undervoltage
// - Bit 15 shows fault
// - Clamp reference magnitude to min/max limits
module dsr_top
    import dsr_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [3:0]  i_digital_inputs,
    input  wire logic        i_alarm,
    input  wire logic        i_fault,
    input  wire logic        i_undervoltage,
    input  wire logic        i_motor_moving,
    output logic      [15:0] o_ramp_reference,
    output logic             o_reverse,
    output logic             o_drive_enable,
    output logic             o_second_ramp
);

    typedef struct packed {
        logic [PRESET_COUNT-1:0][15:0] preset;
        logic [3:0]                    local_src;
        logic [3:0]                    remote_src;
        logic [3:0][7:0]               in_func;
        logic [15:0]                   min_limit;
        logic [15:0]                   max_limit;
        logic [15:0]                   net_ref;
        logic [15:0]                   rated_freq;
        logic [15:0]                   command;
        logic signed [15:0]            pot_ref;
        logic [3:0]                    din_meta;
        logic [3:0]                    din;
        logic [4:0]                    flags_meta;
        logic [4:0]                    flags;
        logic [15:0]                   ramp_ref;
        logic                          reverse;
        logic                          enable;
        logic [15:0]                   status;
        logic [31:0]                   rdata;
        logic                          slverr;
    } dsr_state_s;

    dsr_state_s state;
    dsr_state_s next_state;

    function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic func_is(input logic [3:0][7:0] f, input int idx,
                                     input logic [7:0] a, input logic [7:0] b);
        return (f[idx] == a) || (f[idx] == b);
    endfunction

    logic              remote;
    logic [3:0]        active_src;
    logic              cfg_fault;
    logic [2:0]        sel_index;
    logic signed [15:0] preset_val;
    logic signed [15:0] raw_ref;
    logic signed [15:0] mag;
    logic signed [15:0] lim_mag;
    logic              ref_neg;
    logic              pot_up;
    logic              pot_dn;
    logic [31:0]       net_prod;
    logic              msb_on;
    logic              mid_on;
    logic              lsb_on;
    logic              wr_en;
    logic              rd_en;
    logic [31:0]       rd_word;
    logic              rd_err;
    logic [15:0]       stat;

    always_comb begin
        next_state = state;
        remote     = state.command[CMD_REMOTE];
        active_src = remote ? state.remote_src : state.local_src;
        cfg_fault  = (state.in_func[0] == FN_PRESET_MSB) && (state.in_func[1] == FN_PRESET_MSB);

        // Missing select input reads as high, so weight 0 is added
        msb_on = 1'b1;
        mid_on = 1'b1;
        lsb_on = 1'b1;
        pot_up = 1'b0;
        pot_dn = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (state.in_func[i] == FN_PRESET_MSB && i < 2) begin
                msb_on = state.din[i];
            end
            if (state.in_func[i] == FN_PRESET_MID) begin
                mid_on = state.din[i];
            end
            if (state.in_func[i] == FN_PRESET_LSB) begin
                lsb_on = state.din[i];
            end
            if (func_is(state.in_func, i, FN_POT_UP_A, FN_POT_UP_B) && state.din[i]) begin
                pot_up = 1'b1;
            end
            if (func_is(state.in_func, i, FN_POT_DN_A, FN_POT_DN_B) && state.din[i]) begin
                pot_dn = 1'b1;
            end
        end
        sel_index  = {~msb_on, ~mid_on, ~lsb_on};
        preset_val = state.preset[sel_index];

        net_prod = 32'($signed(state.net_ref) * $signed({1'b0, state.rated_freq}));
        unique case (active_src)
            SRC_PRESET: raw_ref = preset_val;
            SRC_POT:    raw_ref = state.pot_ref;
            SRC_NET:    raw_ref = net_prod[NET_SHIFT+15:NET_SHIFT];
            default:    raw_ref = 16'sh0000;
        endcase

        ref_neg = raw_ref[15];
        mag     = ref_neg ? -raw_ref : raw_ref;
        lim_mag = clamp(mag, $signed(state.min_limit), $signed(state.max_limit));
        next_state.ramp_ref = lim_mag;
        // Command bit 2 gives direction, a negative reference sign flips it
        next_state.reverse  = ~state.command[CMD_FWD] ^ ref_neg;
        next_state.enable   = state.command[CMD_GEN_EN] & ~cfg_fault & ~state.flags[1];

        // Potentiometer: saturates at 0 and at PRESET_MAX
        if (pot_up && pot_dn) begin
            if (!state.command[CMD_GEN_EN]) begin
                next_state.pot_ref = 16'sh0000;
            end
        end else if (active_src == SRC_POT && pot_up && state.pot_ref < PRESET_MAX) begin
            next_state.pot_ref = state.pot_ref + $signed(POT_STEP);
        end else if (active_src == SRC_POT && pot_dn && state.pot_ref > $signed(16'h0000)) begin
            next_state.pot_ref = state.pot_ref - $signed(POT_STEP);
        end

        next_state.din_meta   = i_digital_inputs;
        next_state.din        = state.din_meta;
        next_state.flags_meta = {i_motor_moving, i_undervoltage, i_fault, i_alarm, 1'b0};
        next_state.flags      = state.flags_meta;

        stat                  = 16'h0000;
        stat[ST_RAMP2]        = state.command[CMD_RAMP2];
        stat[ST_CONFIG]       = cfg_fault;
        stat[ST_ALARM]        = state.flags[1];
        stat[ST_RUN]          = state.enable & state.command[CMD_RAMP_EN] & state.flags[4];
        stat[ST_ENABLE]       = state.enable;
        stat[ST_FWD]          = ~state.reverse;
        stat[ST_JOG]          = state.command[CMD_JOG];
        stat[ST_REMOTE]       = remote;
        stat[ST_UNDERV]       = state.flags[3];
        stat[ST_FAULT]        = state.flags[2];
        next_state.status     = stat;

        // APB: zero-wait access, registers updated in access phase
        wr_en   = i_psel & i_penable & i_pwrite;
        rd_en   = i_psel & ~i_penable & ~i_pwrite;
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (i_paddr < ADDR_STATUS) begin
            rd_word = {16'h0000, state.preset[i_paddr[4:2]]};
        end else begin
            unique case (i_paddr)
                ADDR_STATUS:        rd_word = {16'h0000, state.status};
                ADDR_REF_SOURCE:    rd_word = {24'h00_0000, state.remote_src, state.local_src};
                ADDR_INPUT_FUNC:    rd_word = state.in_func;
                ADDR_FREQ_LIMITS:   rd_word = {state.max_limit, state.min_limit};
                ADDR_NET_SPEED_REF: rd_word = {16'h0000, state.net_ref};
                ADDR_RATED_FREQ:    rd_word = {16'h0000, state.rated_freq};
                ADDR_COMMAND:       rd_word = {16'h0000, state.command};
                ADDR_ACTIVE_REF:    rd_word = {16'h0000, state.ramp_ref};
                ADDR_POT_REF:       rd_word = {16'h0000, state.pot_ref};
                default:            rd_err  = 1'b1;
            endcase
        end
        if (rd_en) begin
            next_state.rdata  = rd_word;
            next_state.slverr = rd_err;
        end else if (i_psel & ~i_penable) begin
            next_state.rdata  = 32'h0000_0000;
            next_state.slverr = rd_err | (i_paddr == ADDR_STATUS) | (i_paddr == ADDR_ACTIVE_REF);
        end
        if (wr_en) begin
            if (i_paddr < ADDR_STATUS) begin
                next_state.preset[i_paddr[4:2]] = clamp($signed(i_pwdata[15:0]), PRESET_MIN, PRESET_MAX);
            end else begin
                unique case (i_paddr)
                    ADDR_REF_SOURCE: begin
                        next_state.local_src  = i_pwdata[3:0];
                        next_state.remote_src = i_pwdata[7:4];
                    end
                    ADDR_INPUT_FUNC:    next_state.in_func = i_pwdata;
                    ADDR_FREQ_LIMITS: begin
                        next_state.min_limit = i_pwdata[15:0];
                        next_state.max_limit = i_pwdata[31:16];
                    end
                    ADDR_NET_SPEED_REF: next_state.net_ref    = i_pwdata[15:0];
                    ADDR_RATED_FREQ:    next_state.rated_freq = i_pwdata[15:0];
                    ADDR_COMMAND:       next_state.command    = i_pwdata[15:0];
                    ADDR_POT_REF:       next_state.pot_ref    = clamp($signed(i_pwdata[15:0]), 16'sh0000, PRESET_MAX);
                    default:            next_state.command    = state.command;
                endcase
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state            <= '0;
            state.preset     <= {PRESET_COUNT{PRESET_RESET}};
            state.min_limit  <= MIN_LIMIT_RESET;
            state.max_limit  <= MAX_LIMIT_RESET;
            state.rated_freq <= RATED_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_prdata         = state.rdata;
    assign o_pready         = 1'b1;
    assign o_pslverr        = i_psel & i_penable & state.slverr;
    assign o_ramp_reference = state.ramp_ref;
    assign o_reverse        = state.reverse;
    assign o_drive_enable   = state.enable;
    assign o_second_ramp    = state.command[CMD_RAMP2];

endmodule

//--- dsr_top_asserts.sv
`timescale 1ns/1ps
module dsr_top_chk
    import dsr_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_resetn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [3:0]  i_digital_inputs,
    input wire logic        i_alarm,
    input wire logic        i_fault,
    input wire logic        i_undervoltage,
    input wire logic        i_motor_moving,
    input wire logic [15:0] o_ramp_reference,
    input wire logic        o_reverse,
    input wire logic        o_drive_enable,
    input wire logic        o_second_ramp
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic acc;
    logic st_rd;
    assign acc   = i_psel & i_penable;
    assign st_rd = acc & !i_pwrite & (i_paddr == ADDR_STATUS);
    property p_ready; acc |-> o_pready; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_st_wr; acc && i_pwrite && i_paddr == ADDR_STATUS |-> o_pslverr; endproperty
    a_st_wr: assert property (p_st_wr) else $error("status write not refused");
    property p_unmap; acc && i_paddr > 8'h40 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0000_0000); endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access wrong");
    property p_resv; st_rd |-> o_prdata[4:0] == 5'h00 && !o_prdata[14] && o_prdata[31:16] == 16'h0000; endproperty
    a_resv: assert property (p_resv) else $error("reserved status bits set");
    property p_map_ok; acc && !i_pwrite && i_paddr <= 8'h40 && i_paddr[1:0] == 2'b00 |-> !o_pslverr; endproperty
    a_map_ok: assert property (p_map_ok) else $error("mapped read errored");
    property p_alarm; i_alarm [*5] |=> !o_drive_enable; endproperty
    a_alarm: assert property (p_alarm) else $error("enabled under alarm");
    property p_cfg; st_rd && o_prdata[ST_CONFIG] |-> !o_drive_enable; endproperty
    a_cfg: assert property (p_cfg) else $error("enabled in config state");
    property p_ramp2; acc && i_pwrite && i_paddr == ADDR_COMMAND && i_pwdata[CMD_RAMP2] |-> ##[1:3] o_second_ramp;
    endproperty
    a_ramp2: assert property (p_ramp2) else $error("second ramp not taken");
    c_st: cover property (st_rd);
    c_rev: cover property (o_reverse && o_drive_enable);
    c_err: cover property (o_pslverr);
endmodule
bind dsr_top dsr_top_chk i_dsr_top_chk (.*);

//--- dsr_terminals.sv
`timescale 1ns/1ps
module dsr_terminals (
    input  wire logic       i_ref_clk,
    output logic      [3:0] o_inputs,
    output logic      [3:0] o_flags
);
    // Contacts and drive flags are levels held until the next call
    initial begin
        o_inputs = 4'h0;
        o_flags  = 4'h0;
    end
    task automatic drive(input logic [3:0] di, input logic [3:0] fl);
        o_inputs <= di;
        o_flags  <= fl;
    endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import dsr_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  di;
    logic [3:0]  fl;
    logic [15:0] ramp;
    logic        rev;
    logic        en;
    logic        r2;
    int          failures = 0;
    int          total_checks = 0;
    always #5 clk = ~clk;
    dsr_terminals i_dsr_terminals (.i_ref_clk(clk), .o_inputs(di), .o_flags(fl));
    dsr_top i_dsr_top (.i_ref_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_digital_inputs(di), .i_alarm(fl[3]), .i_fault(fl[2]), .i_undervoltage(fl[1]), .i_motor_moving(fl[0]),
        .o_ramp_reference(ramp), .o_reverse(rev), .o_drive_enable(en), .o_second_ramp(r2));
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Request stands until ready is seen high at a rising edge
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic s_preset();
        int v[8] = '{10, -4000, 300, 400, -500, 600, 700, 4000};
        int m[8] = '{30, 3000, 300, 400, 500, 600, 700, 3000};
        logic [31:0] r;
        logic e;
        logic [2:0] x;
        int c;
        wr(ADDR_REF_SOURCE, 32'h0000_0008);
        wr(ADDR_INPUT_FUNC, 32'h0F0E_000D);
        wr(ADDR_FREQ_LIMITS, 32'h0BB8_001E);
        wr(ADDR_COMMAND, 32'h0000_0007);
        for (int i = 0; i < 8; i++) begin
            c = v[i] > 3000 ? 3000 : (v[i] < -3000 ? -3000 : v[i]);
            wr(ADDR_PRESET_BASE + 8'(4 * i), {16'h0000, 16'(v[i])});
            apb(1'b0, ADDR_PRESET_BASE + 8'(4 * i), 32'h0000_0000, r, e);
            check("preset", {16'h0000, r[15:0]}, {16'h0000, 16'(c)});
        end
        for (int i = 0; i < 8; i++) begin
            x = 3'(i);
            // A 0 V input adds its weight, so drive the complement
            i_dsr_terminals.drive({~x[0], ~x[1], 1'b0, ~x[2]}, 4'h0);
            repeat (8) @(posedge clk);
            check("ramp_ref", {16'h0000, ramp}, 32'(m[i]));
            check("reverse", {31'h0, rev}, {31'h0, v[i] < 0});
        end
    endtask
    task automatic s_config();
        logic [31:0] r;
        logic e;
        wr(ADDR_INPUT_FUNC, 32'h0F0E_0D0D);
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, r, e);
        check("cfg_bit", {31'h0, r[ST_CONFIG]}, 32'h0000_0001);
        check("enable", {31'h0, en}, 32'h0000_0000);
        wr(ADDR_INPUT_FUNC, 32'h0F0E_000D);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, r, e);
        check("cfg_bit", {31'h0, r[ST_CONFIG]}, 32'h0000_0000);
    endtask
    task automatic s_pot();
        logic [7:0] up[2] = '{FN_POT_UP_A, FN_POT_UP_B};
        logic [7:0] dn[2] = '{FN_POT_DN_B, FN_POT_DN_A};
        logic [31:0] p0;
        logic [31:0] r;
        logic e;
        wr(ADDR_REF_SOURCE, 32'h0000_0007);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_INPUT_FUNC, {16'h0000, dn[k], up[k]});
            wr(ADDR_COMMAND, 32'h0000_0007);
            apb(1'b0, ADDR_POT_REF, 32'h0000_0000, p0, e);
            i_dsr_terminals.drive(4'h1, 4'h0);
            repeat (10) @(posedge clk);
            i_dsr_terminals.drive(4'h2, 4'h0);
            repeat (4) @(posedge clk);
            i_dsr_terminals.drive(4'h0, 4'h0);
            repeat (6) @(posedge clk);
            apb(1'b0, ADDR_POT_REF, 32'h0000_0000, r, e);
            check("pot_ref", r, p0 + 32'h0000_0006);
            wr(ADDR_COMMAND, 32'h0000_0000);
            i_dsr_terminals.drive(4'h3, 4'h0);
            repeat (4) @(posedge clk);
            i_dsr_terminals.drive(4'h0, 4'h0);
            repeat (6) @(posedge clk);
            apb(1'b0, ADDR_POT_REF, 32'h0000_0000, r, e);
            check("pot_clear", r, 32'h0000_0000);
        end
    endtask
    task automatic s_net_status();
        int nv[3] = '{8192, 4096, 24576};
        logic [31:0] r;
        logic e;
        wr(ADDR_REF_SOURCE, 32'h0000_0099);
        wr(ADDR_RATED_FREQ, 32'h0000_0258);
        wr(ADDR_COMMAND, 32'h0000_003F);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_NET_SPEED_REF, {16'h0000, 16'(nv[i])});
            repeat (6) @(posedge clk);
            check("net_ref", {16'h0000, ramp}, 32'(nv[i] * 600 / 8192));
        end
        i_dsr_terminals.drive(4'h0, 4'b0111);
        repeat (8) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, r, e);
        check("status", r, 32'h0000_BF20);
        check("ramp2", {31'h0, r2}, 32'h0000_0001);
        i_dsr_terminals.drive(4'h0, 4'b1111);
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_STATUS, 32'h0000_0000, r, e);
        check("st_wr_err", {31'h0, e}, 32'h0000_0001);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, r, e);
        check("status", r, 32'h0000_BCA0);
        apb(1'b0, 8'h44, 32'h0000_0000, r, e);
        check("unmapped", {e, r[30:0]}, 32'h8000_0000);
        i_dsr_terminals.drive(4'h0, 4'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        s_preset();
        s_config();
        s_pot();
        s_net_status();
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end
endmodule
